// file: src/blce_alu.sv
// combinational and/bit-set datapath
module blce_alu
  import blce_pkg::*;
(
  input  wire logic [DATA_W-1:0] acc,
  input  wire logic [DATA_W-1:0] opnd,
  input  wire logic [2:0]        bit_sel,
  output logic      [DATA_W-1:0] and_res,
  output logic                   and_zero,
  output logic      [DATA_W-1:0] set_res,
  output logic                   bit_val
);
  always_comb
  begin
    and_res  = acc & opnd;
    and_zero = (and_res == 8'h00);
    set_res  = opnd | (8'h01 << bit_sel);
    bit_val  = opnd[bit_sel];
  end
endmodule : blce_alu

// file: src/blce_core.sv
// execution of and, bit set/test, clear and call instructions
module blce_core
  import blce_pkg::*;
(
  input  wire logic                 mclk,
  input  wire logic                 nrst,
  input  wire logic                 instr_valid,
  input  wire logic [OP_W-1:0]      instr,
  input  wire logic [DATA_W-1:0]    file_rdata,
  input  wire logic [DATA_W-1:0]    status_in,
  output logic      [FADDR_W-1:0]   file_addr,
  output logic                      file_we,
  output logic      [DATA_W-1:0]    file_wdata,
  output logic      [DATA_W-1:0]    acc_out,
  output logic                      zero_we,
  output logic                      zero_out,
  output logic      [PC_W-1:0]      pc_out,
  output logic                      push_en,
  output logic      [PC_W-1:0]      push_data,
  output logic                      flush,
  output logic                      busy
);
  // the register file is read combinationally from the f field of instr; file_addr is its registered write address
  blce_state_t               state_reg,     state_next;
  logic [DATA_W-1:0]         acc_reg,       acc_next;
  logic                      zwe_reg,       zwe_next;
  logic                      z_reg,         z_next;
  logic [PC_W-1:0]           pc_reg,        pc_next;
  logic                      push_reg,      push_next;
  logic [PC_W-1:0]           pdat_reg,      pdat_next;
  logic                      fwe_reg,       fwe_next;
  logic [DATA_W-1:0]         fwd_reg,       fwd_next;
  logic [FADDR_W-1:0]        fadr_reg,      fadr_next;
  logic                      flush_reg,     flush_next;
  logic                      busy_reg,      busy_next;
  logic [DATA_W-1:0]         and_lit,       and_file;
  logic                      zero_lit,      zero_file;
  logic [DATA_W-1:0]         set_res;
  logic                      bit_val;
  logic [3:0]                hi4;
  logic [DATA_W-1:0]         k;
  logic                      is_and_lit,    is_and_file;
  logic                      is_set_bit,    is_skip;
  logic                      is_clr_acc,    is_call;
  logic [PC_W-1:0]           call_pc;

  // single pc step shared by plain, call and nop cycles, wraps at the top
  function automatic logic [PC_W-1:0] pc_inc(input logic [PC_W-1:0] p);
    return p + 11'h001;
  endfunction : pc_inc

  assign hi4 = instr[OP_HI4_MSB:OP_HI4_LSB];
  assign k   = instr[OP_K_MSB:OP_K_LSB];

  // decode sits apart from the datapath so each branch reads as one rule
  assign is_and_lit  = (hi4 == OPC_AND_LIT);
  assign is_and_file = (instr[OP_HI4_MSB:6] == OPC_AND_FILE);
  assign is_set_bit  = (hi4 == OPC_SET_BIT);
  // the tested bit comes from the same combinational file read
  assign is_skip     = ((hi4 == OPC_SKIP_ZERO) && !bit_val)
                       || ((hi4 == OPC_SKIP_ONE) && bit_val);
  assign is_clr_acc  = (instr == OPC_CLR_ACC);
  assign is_call     = (hi4 == OPC_CALL);
  // bit 8 is forced low; a callee always starts in a page's lower half
  assign call_pc = {status_in[ST_PAGE_MSB:ST_PAGE_LSB], 1'b0, k};

  blce_alu u_lit (
    .acc      (acc_reg),
    .opnd     (k),
    .bit_sel  (instr[OP_BIT_MSB:OP_BIT_LSB]),
    .and_res  (and_lit),
    .and_zero (zero_lit),
    .set_res  (),
    .bit_val  ()
  );

  blce_alu u_file (
    .acc      (acc_reg),
    .opnd     (file_rdata),
    .bit_sel  (instr[OP_BIT_MSB:OP_BIT_LSB]),
    .and_res  (and_file),
    .and_zero (zero_file),
    .set_res  (set_res),
    .bit_val  (bit_val)
  );

  always_comb
  begin
    state_next = state_reg;
    acc_next   = acc_reg;
    zwe_next   = 1'b0;
    z_next     = z_reg;
    pc_next    = pc_reg;
    push_next  = 1'b0;
    pdat_next  = pdat_reg;
    fwe_next   = 1'b0;
    fwd_next   = fwd_reg;
    fadr_next  = instr[OP_F_MSB:OP_F_LSB];
    flush_next = 1'b0;
    busy_next  = 1'b0;
    case (state_reg)
      BLCE_EXEC:
      begin
        // undecoded words only step the pc, so they act as a nop
        if (instr_valid)
        begin
          pc_next = pc_inc(pc_reg);
          if (is_and_lit)
          begin
            acc_next = and_lit;
            zwe_next = 1'b1;
            z_next   = zero_lit;
          end
          else if (is_and_file)
          begin
            zwe_next = 1'b1;
            z_next   = zero_file;
            if (instr[OP_DEST_BIT])
            begin
              fwe_next = 1'b1;
              fwd_next = and_file;
            end
            else
              acc_next = and_file;
          end
          else if (is_set_bit)
          begin
            fwe_next = 1'b1;
            fwd_next = set_res;
          end
          else if (is_skip)
          begin
            // prefetched word is dropped; a nop cycle follows
            flush_next = 1'b1;
            busy_next  = 1'b1;
            state_next = BLCE_FLUSH;
          end
          else if (is_clr_acc)
          begin
            acc_next = ACC_RST;
            zwe_next = 1'b1;
            z_next   = 1'b1;
          end
          else if (is_call)
          begin
            push_next  = 1'b1;
            pdat_next  = pc_inc(pc_reg);
            pc_next    = call_pc;
            flush_next = 1'b1;
            busy_next  = 1'b1;
            state_next = BLCE_FLUSH;
          end
        end
      end
      BLCE_FLUSH:
      begin
        // second cycle executes a nop, no flags touched
        // any word offered now is the discarded prefetch
        pc_next    = pc_inc(pc_reg);
        state_next = BLCE_EXEC;
      end
      default:
        state_next = BLCE_EXEC;
    endcase
  end

  // reset wins over a pending nop slot, so busy never outlives it
  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      state_reg <= BLCE_EXEC;
      acc_reg   <= ACC_RST;
      zwe_reg   <= 1'b0;
      z_reg     <= 1'b0;
      pc_reg    <= PC_RST;
      push_reg  <= 1'b0;
      pdat_reg  <= PC_RST;
      fwe_reg   <= 1'b0;
      fwd_reg   <= 8'h00;
      fadr_reg  <= 5'h00;
      flush_reg <= 1'b0;
      busy_reg  <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      acc_reg   <= acc_next;
      zwe_reg   <= zwe_next;
      z_reg     <= z_next;
      pc_reg    <= pc_next;
      push_reg  <= push_next;
      pdat_reg  <= pdat_next;
      fwe_reg   <= fwe_next;
      fwd_reg   <= fwd_next;
      fadr_reg  <= fadr_next;
      flush_reg <= flush_next;
      busy_reg  <= busy_next;
    end
  end

  assign file_addr  = fadr_reg;
  assign file_we    = fwe_reg;
  assign file_wdata = fwd_reg;
  assign acc_out    = acc_reg;
  assign zero_we    = zwe_reg;
  assign zero_out   = z_reg;
  assign pc_out     = pc_reg;
  assign push_en    = push_reg;
  assign push_data  = pdat_reg;
  assign flush      = flush_reg;
  assign busy       = busy_reg;
endmodule : blce_core

// file: src/blce_pkg.sv
// shared constants for the bit logic and call executor
package blce_pkg;
  localparam int          DATA_W       = 8;
  localparam int          FADDR_W      = 5;
  localparam int          PC_W         = 11;
  localparam int          OP_W         = 12;
  // opcode fields
  localparam int          OP_HI4_MSB   = 11;
  localparam int          OP_HI4_LSB   = 8;
  localparam int          OP_DEST_BIT  = 5;
  localparam int          OP_BIT_MSB   = 7;
  localparam int          OP_BIT_LSB   = 5;
  localparam int          OP_F_MSB     = 4;
  localparam int          OP_F_LSB     = 0;
  localparam int          OP_K_MSB     = 7;
  localparam int          OP_K_LSB     = 0;
  localparam logic [3:0]  OPC_AND_LIT  = 4'hE;
  localparam logic [3:0]  OPC_CALL     = 4'h9;
  localparam logic [3:0]  OPC_SET_BIT  = 4'h5;
  localparam logic [3:0]  OPC_SKIP_ZERO = 4'h6;
  localparam logic [3:0]  OPC_SKIP_ONE = 4'h7;
  localparam logic [5:0]  OPC_AND_FILE = 6'h05;
  localparam logic [11:0] OPC_CLR_ACC  = 12'h040;
  localparam logic [11:0] OPC_NOP      = 12'h000;
  // status page bits
  localparam int          ST_PAGE_MSB  = 6;
  localparam int          ST_PAGE_LSB  = 5;
  localparam int          PC_PAGE_MSB  = 10;
  localparam int          PC_PAGE_LSB  = 9;
  localparam int          PC_B8        = 8;
  localparam logic [7:0]  ACC_RST      = 8'h00;
  localparam logic [10:0] PC_RST       = 11'h000;
  typedef enum logic [0:0] {
    BLCE_EXEC  = 1'b0,
    BLCE_FLUSH = 1'b1
  } blce_state_t;
endpackage : blce_pkg

// file: verif/blce_asserts.sv
// assertions for the bit logic and call executor
module blce_asserts
  import blce_pkg::*;
(
  input wire logic        mclk,
  input wire logic        nrst,
  input wire logic        instr_valid,
  input wire logic [11:0] instr,
  input wire logic [7:0]  file_rdata,
  input wire logic [7:0]  status_in,
  input wire logic [4:0]  file_addr,
  input wire logic        file_we,
  input wire logic [7:0]  file_wdata,
  input wire logic [7:0]  acc_out,
  input wire logic        zero_we,
  input wire logic        zero_out,
  input wire logic [10:0] pc_out,
  input wire logic        push_en,
  input wire logic [10:0] push_data,
  input wire logic        flush,
  input wire logic        busy
);
  wire       tk = instr_valid && !busy;
  wire [3:0] op = instr[11:8];
  wire       aw = instr[11:6] == OPC_AND_FILE;
  wire       bv = file_rdata[instr[7:5]];
  wire [7:0] av = acc_out & (aw ? file_rdata : instr[7:0]);
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  // nop slot shared by skips and calls, flags left alone
  sequence nop_s;
    flush && busy && !zero_we ##1 !busy;
  endsequence
  and_lit_a: assert property (
    tk && op == OPC_AND_LIT |=> acc_out == $past(av))
    else $error("and literal result wrong");
  zero_flag_a: assert property (
    tk && (op == OPC_AND_LIT || aw) |=>
    zero_we && zero_out == ($past(av) == 8'h00))
    else $error("zero flag wrong after and");
  and_file_a: assert property (
    tk && aw |=> ($past(instr[5]) ? file_we && file_wdata == $past(av) &&
    file_addr == $past(instr[4:0]) : !file_we && acc_out == $past(av)))
    else $error("and with file destination wrong");
  bit_set_a: assert property (
    tk && op == OPC_SET_BIT |=> file_we && !zero_we &&
    file_wdata == ($past(file_rdata) | (8'h01 << $past(instr[7:5]))))
    else $error("bit set result wrong");
  bit_skip_a: assert property (
    tk && (op == OPC_SKIP_ZERO && !bv || op == OPC_SKIP_ONE && bv) |=> nop_s)
    else $error("skip did not discard next word");
  clr_acc_a: assert property (
    tk && instr == OPC_CLR_ACC |=> acc_out == 8'h00 && zero_out && zero_we)
    else $error("clear accumulator wrong");
  call_push_a: assert property (
    tk && op == OPC_CALL |=> push_en && push_data == $past(pc_out) + 11'h001)
    else $error("call pushed wrong return address");
  call_dest_a: assert property (
    tk && op == OPC_CALL |=> pc_out ==
    {$past(status_in[6:5]), 1'b0, $past(instr[7:0])} ##0 nop_s)
    else $error("call target or timing wrong");
  busy_slot_a: assert property (
    busy |=> !file_we && !zero_we && !push_en && !flush &&
    pc_out == $past(pc_out) + 11'h001)
    else $error("nop slot did not behave as a nop");
endmodule : blce_asserts
bind blce_core blce_asserts u_blce_asserts (
  .mclk        (mclk),
  .nrst        (nrst),
  .instr_valid (instr_valid),
  .instr       (instr),
  .file_rdata  (file_rdata),
  .status_in   (status_in),
  .file_addr   (file_addr),
  .file_we     (file_we),
  .file_wdata  (file_wdata),
  .acc_out     (acc_out),
  .zero_we     (zero_we),
  .zero_out    (zero_out),
  .pc_out      (pc_out),
  .push_en     (push_en),
  .push_data   (push_data),
  .flush       (flush),
  .busy        (busy)
);

// file: verif/tb.sv
// self-checking bench for the bit logic and call executor
module tb
  import blce_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        mclk = 1'b0, nrst = 1'b0, instr_valid = 1'b0;
  logic [11:0] instr = 12'h000;
  logic [7:0]  status_in = 8'h00, acc_out, file_wdata;
  logic [7:0]  rf [32] = '{default: 8'h00};
  logic [4:0]  file_addr;
  logic [10:0] pc_out, push_data, pe = 11'h000;
  logic        file_we, zero_we, zero_out, push_en, flush, busy;
  int          err_total = 0, check_count = 0;
  wire  [7:0]  file_rdata = rf[instr[4:0]];
  blce_core u_blce_core (
    .mclk        (mclk),
    .nrst        (nrst),
    .instr_valid (instr_valid),
    .instr       (instr),
    .file_rdata  (file_rdata),
    .status_in   (status_in),
    .file_addr   (file_addr),
    .file_we     (file_we),
    .file_wdata  (file_wdata),
    .acc_out     (acc_out),
    .zero_we     (zero_we),
    .zero_out    (zero_out),
    .pc_out      (pc_out),
    .push_en     (push_en),
    .push_data   (push_data),
    .flush       (flush),
    .busy        (busy)
  );
  initial
    forever #10 mclk = ~mclk;
  always @(posedge mclk)
    if (file_we) rf[file_addr] <= file_wdata;
  task chk(input logic [31:0] g, e);
    check_count++;
    if (g !== e)
    begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask : chk
  // idle cycle first, so valid is never assigned twice in one step
  task exec(input logic [11:0] op);
    @(negedge mclk);
    instr = op;
    instr_valid = 1'b1;
    @(negedge mclk);
    instr_valid = 1'b0;
    pe = pe + 11'h001;
  endtask : exec
  task t_and;
    exec(OPC_CLR_ACC);
    chk({acc_out, zero_we, zero_out}, 10'h003);
    exec(12'hEFF);
    chk({acc_out, zero_we, zero_out}, 10'h003);
    rf[3] = 8'hA5;
    exec(12'h163);
    chk({file_we, file_addr, file_wdata}, 14'h2300);
    exec(12'h143);
    chk({file_we, acc_out, zero_we, pc_out}, {10'h001, pe});
    $display("and tests done");
  endtask : t_and
  task t_bsf;
    logic [7:0] v;
    v = 8'h00;
    for (int b = 0; b < 8; b++)
    begin
      exec({4'h5, b[2:0], 5'h1F});
      v[b] = 1'b1;
      chk({file_we, zero_we, file_addr, file_wdata}, {7'h5F, v});
    end
    $display("bit set tests done");
  endtask : t_bsf
  task t_skip;
    logic s;
    rf[7] = 8'h5A;
    for (int i = 0; i < 16; i++)
    begin
      exec({3'h3, i[3:0], 5'h07});
      s = i[3] ~^ rf[7][i[2:0]];
      chk({flush, busy, zero_we, pc_out}, {s, s, 1'b0, pe});
      if (s)
      begin
        @(negedge mclk);
        pe = pe + 11'h001;
        chk({busy, pc_out}, {1'b0, pe});
      end
    end
    $display("bit test tests done");
  endtask : t_skip
  // a bit set offered in the busy slot must be ignored
  task t_call;
    for (int i = 0; i < 2; i++)
    begin
      @(negedge mclk);
      status_in = i ? 8'hC0 : 8'h3F;
      instr = {4'h9, i ? 8'h5A : 8'hA5};
      instr_valid = 1'b1;
      @(negedge mclk);
      chk({push_en, push_data}, {1'b1, pe + 11'h001});
      pe = {status_in[6:5], 1'b0, instr[7:0]};
      chk({pc_out, flush, busy, zero_we}, {pe, 3'b110});
      instr = 12'h500;
      @(negedge mclk);
      instr_valid = 1'b0;
      pe = pe + 11'h001;
      chk({pc_out, busy, file_we}, {pe, 2'b00});
    end
    $display("call tests done");
  endtask : t_call
  // reset dropped in the nop slot of a call must clear everything
  task t_reset;
    @(negedge mclk);
    instr = {OPC_CALL, 8'hA5};
    instr_valid = 1'b1;
    @(negedge mclk);
    instr_valid = 1'b0;
    nrst = 1'b0;
    @(negedge mclk);
    chk({busy, flush, push_en, zero_out, pc_out, acc_out}, 23'h0);
    nrst = 1'b1;
    pe = 11'h000;
    exec(OPC_CLR_ACC);
    chk({busy, pc_out, zero_out}, {1'b0, pe, 1'b1});
    $display("reset tests done");
  endtask : t_reset
  task finish_test;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : finish_test
  initial
  begin
    repeat (12) @(negedge mclk);
    chk({pc_out, busy, acc_out}, 20'h0);
    nrst = 1'b1;
    t_and;
    t_bsf;
    t_skip;
    t_call;
    t_reset;
    finish_test;
  end
endmodule : tb
